// ===== design/fpm_flash_ctrl.sv
// Flash program-mode controller: mode entry, protection and write sequencer.
// Assumes a flash macro behind the mem_ port and a core that feeds the latches.
`timescale 1ns/1ps
module fpm_flash_ctrl (
  // Core clock and reset
  input wire logic clock,
  input wire logic rst,
  // Board pins
  input wire logic reset_pin_n_in,
  input wire logic socket_strap_in,
  input wire logic external_clock_present_in,
  input wire logic [1:0] option_sector0_size,
  // In-circuit link pins
  input wire logic incircuit_link_clock_pin,
  input wire logic incircuit_link_data_pin_in,
  output logic incircuit_link_clock_pin_out,
  output logic incircuit_link_clock_pin_oe,
  output logic incircuit_link_clock_pin_pullup,
  output logic incircuit_link_data_pin_out,
  output logic incircuit_link_data_pin_oe,
  // Application use of the link clock pin
  input wire logic app_clock_pin_drive,
  input wire logic app_clock_pin_value,
  // Core side requests
  input wire logic key_write,
  input wire logic [7:0] key_data,
  input wire logic latch_write,
  input wire logic [4:0] latch_index,
  input wire logic [7:0] latch_data,
  input wire logic op_start,
  input wire logic op_erase,
  input wire logic [1:0] op_area,
  input wire logic [12:0] op_row_addr,
  input wire logic [5:0] op_count,
  input wire logic driver_start,
  // Status
  output logic op_busy,
  output logic op_done,
  output logic op_refused,
  output logic [1:0] program_mode,
  output logic [1:0] incircuit_step,
  output logic [15:0] boot_vector,
  output logic core_hold,
  output logic use_external_clock,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  // Flash macro
  output logic mem_write,
  output logic mem_erase,
  output logic [1:0] mem_area,
  output logic [12:0] mem_addr,
  output logic [7:0] mem_wdata
);
  // Link domain
  logic entry_toggle;
  logic byte_toggle;
  logic [7:0] byte_hold;

  fpm_link_rx u_link_rx (
    .link_clock(incircuit_link_clock_pin),
    .rst(rst),
    .data_pin_in(incircuit_link_data_pin_in),
    .reset_pin_n_in(reset_pin_n_in),
    .entry_toggle(entry_toggle),
    .byte_toggle(byte_toggle),
    .byte_hold(byte_hold)
  );

  // Pin synchronisers: three flops, a change counts once two agree
  localparam int NPIN = 5;
  wire [NPIN-1:0] pin_raw = {byte_toggle, entry_toggle, external_clock_present_in,
                             socket_strap_in, reset_pin_n_in};
  // All start low, so the strap is caught only after real pin levels arrive
  localparam logic [NPIN-1:0] PIN_RESET = 5'h00;
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_s3;
  logic [NPIN-1:0] pin_level;
  logic [NPIN-1:0] pin_prev;
  logic [NPIN-1:0] pin_change;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          pin_s1[gi] <= PIN_RESET[gi];
          pin_s2[gi] <= PIN_RESET[gi];
          pin_s3[gi] <= PIN_RESET[gi];
          pin_level[gi] <= PIN_RESET[gi];
          pin_prev[gi] <= PIN_RESET[gi];
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi]) begin
            pin_level[gi] <= pin_s3[gi];
          end
          pin_prev[gi] <= pin_level[gi];
        end
      end
      assign pin_change[gi] = pin_level[gi] != pin_prev[gi];
    end
  endgenerate

  wire reset_held = !pin_level[0];
  wire reset_release = pin_level[0] && !pin_prev[0];
  wire reset_fall = !pin_level[0] && pin_prev[0];
  wire entry_event = pin_change[3];
  wire byte_event = pin_change[4];

  // Mode state
  logic strap_taken;
  logic socket_mode;
  logic entry_pending;
  logic incircuit;
  wire in_any_reset = reset_held || !strap_taken;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_taken <= 1'b0;
      socket_mode <= 1'b0;
      entry_pending <= 1'b0;
      incircuit <= 1'b0;
    end else begin
      // Strap caught once the synchroniser has settled after reset
      if (!strap_taken && pin_level[0]) begin
        strap_taken <= 1'b1;
        socket_mode <= pin_level[1];
      end
      if (reset_fall) begin
        entry_pending <= 1'b0;
      end else if (reset_held && entry_event) begin
        entry_pending <= 1'b1; // R8
      end
      // Mode is decided only at reset release and kept till the next one
      if (reset_release) begin
        incircuit <= entry_pending; // R16
      end
    end
  end

  // In-circuit session steps and received bytes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      incircuit_step <= fpm_pkg::STEP_OFF;
      boot_vector <= fpm_pkg::USER_RESET_VECTOR;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (reset_release) begin
        incircuit_step <= entry_pending ? fpm_pkg::STEP_ENTER : fpm_pkg::STEP_OFF; // R10
        boot_vector <= entry_pending ? fpm_pkg::SYSTEM_RESET_VECTOR
                                     : fpm_pkg::USER_RESET_VECTOR; // R9
      end else if (incircuit && !reset_held) begin
        if (incircuit_step == fpm_pkg::STEP_ENTER) begin
          incircuit_step <= fpm_pkg::STEP_DOWNLOAD; // R10
        end else if (incircuit_step == fpm_pkg::STEP_DOWNLOAD && driver_start) begin
          incircuit_step <= fpm_pkg::STEP_EXECUTE; // R10
        end
        // Held byte is stable for eight link clocks, far beyond the sync delay
        if (byte_event && incircuit_step == fpm_pkg::STEP_DOWNLOAD) begin
          rx_byte <= byte_hold; // R12
          rx_valid <= 1'b1;
        end
      end
    end
  end

  // Pins, clock source and core hold
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      incircuit_link_clock_pin_out <= 1'b0;
      incircuit_link_clock_pin_oe <= 1'b0;
      incircuit_link_clock_pin_pullup <= 1'b1;
      incircuit_link_data_pin_out <= 1'b0;
      incircuit_link_data_pin_oe <= 1'b0;
      use_external_clock <= 1'b0;
      core_hold <= 1'b1;
      program_mode <= fpm_pkg::PMODE_SELF;
    end else begin
      // Any reset, pin or system, turns the clock pin into a pulled-up input
      incircuit_link_clock_pin_oe <= !in_any_reset && !incircuit && app_clock_pin_drive; // R15
      incircuit_link_clock_pin_out <= app_clock_pin_value;
      incircuit_link_clock_pin_pullup <= in_any_reset || incircuit || !app_clock_pin_drive; // R15
      incircuit_link_data_pin_out <= 1'b0;
      incircuit_link_data_pin_oe <= 1'b0;
      use_external_clock <= pin_level[2] && (entry_pending || incircuit || socket_mode); // R13
      core_hold <= in_any_reset;
      if (incircuit) begin
        program_mode <= fpm_pkg::PMODE_INCIRCUIT;
      end else if (socket_mode) begin
        program_mode <= fpm_pkg::PMODE_SOCKET;
      end else begin
        program_mode <= fpm_pkg::PMODE_SELF;
      end
    end
  end

  // Unlock keys
  fpm_pkg::fpm_key_t key_state;
  fpm_pkg::fpm_seq_t seq;
  wire op_finish;
  wire op_reject;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      key_state <= fpm_pkg::key_locked;
    end else if (op_finish || op_reject) begin
      key_state <= fpm_pkg::key_locked;
    end else if (key_write) begin
      case (key_state)
        fpm_pkg::key_locked: begin
          key_state <= (key_data == fpm_pkg::KEY_FIRST) ? fpm_pkg::key_half
                                                       : fpm_pkg::key_locked; // R14
        end
        fpm_pkg::key_half: begin
          key_state <= (key_data == fpm_pkg::KEY_SECOND) ? fpm_pkg::key_open
                                                        : fpm_pkg::key_locked; // R14
        end
        default: begin
          key_state <= key_state;
        end
      endcase
    end
  end

  // Protection
  wire [12:0] sector0_top = (option_sector0_size == 2'h0) ? fpm_pkg::SECTOR0_SIZE_0 :
                            (option_sector0_size == 2'h1) ? fpm_pkg::SECTOR0_SIZE_1 :
                            (option_sector0_size == 2'h2) ? fpm_pkg::SECTOR0_SIZE_2 :
                                                            fpm_pkg::SECTOR0_SIZE_3; // R3
  wire full_access = socket_mode || incircuit; // R4 R5
  wire self_ok = (op_area == fpm_pkg::AREA_EEPROM) ||
                 (op_area == fpm_pkg::AREA_PROGRAM && op_row_addr >= sector0_top); // R6
  wire area_ok = full_access ? (op_area != 2'h3) : self_ok;
  // In-circuit flash work waits for the downloaded driver to run
  wire step_ok = !incircuit || incircuit_step == fpm_pkg::STEP_EXECUTE; // R10
  wire count_ok = op_erase || (op_count != 6'h00 && op_count <= fpm_pkg::MAX_BURST); // R1
  wire start_seen = op_start && seq == fpm_pkg::seq_idle && !in_any_reset;
  wire op_accept = start_seen && key_state == fpm_pkg::key_open && area_ok && step_ok
                   && count_ok;
  assign op_reject = start_seen && !op_accept;

  // Data latches
  logic [7:0] latch [fpm_pkg::LATCH_DEPTH];
  logic [fpm_pkg::LATCH_DEPTH-1:0] latch_used;
  wire latch_clear = op_finish;

  generate
    for (gi = 0; gi < fpm_pkg::LATCH_DEPTH; gi++) begin : g_latch
      wire hit = latch_write && seq == fpm_pkg::seq_idle &&
                 latch_index == fpm_pkg::LATCH_AW'(gi);
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          latch[gi] <= 8'hFF;
          latch_used[gi] <= 1'b0;
        end else if (latch_clear) begin
          latch[gi] <= 8'hFF;
          latch_used[gi] <= 1'b0;
        end else if (hit) begin
          // Rewriting a latch before programming ANDs the data, as the cells would
          latch[gi] <= latch[gi] & latch_data;
          latch_used[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // Sequencer
  fpm_pkg::fpm_seq_t next_seq;
  logic [1:0] cur_area;
  logic [12:0] cur_row;
  logic [5:0] cur_count;
  logic [4:0] idx;
  logic [9:0] timer;
  wire last_byte = {1'b0, idx} == cur_count - 6'h01;
  wire timer_done = timer == 10'h000;
  assign op_finish = seq == fpm_pkg::seq_wait && timer_done;

  always_comb begin
    next_seq = seq;
    case (seq)
      fpm_pkg::seq_idle: begin
        if (op_accept) begin
          next_seq = op_erase ? fpm_pkg::seq_erase : fpm_pkg::seq_write;
        end
      end
      fpm_pkg::seq_write: begin
        if (last_byte) begin
          next_seq = fpm_pkg::seq_wait;
        end
      end
      fpm_pkg::seq_erase: begin
        next_seq = fpm_pkg::seq_wait;
      end
      default: begin
        if (timer_done) begin
          next_seq = fpm_pkg::seq_idle;
        end
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seq <= fpm_pkg::seq_idle;
      cur_area <= fpm_pkg::AREA_PROGRAM;
      cur_row <= 13'h0000;
      cur_count <= 6'h00;
      idx <= 5'h00;
      timer <= 10'h000;
    end else begin
      seq <= next_seq;
      if (op_accept) begin
        cur_area <= op_area;
        // Row base only: all bytes of one burst share the upper address bits
        cur_row <= {op_row_addr[12:5], 5'h00};
        cur_count <= op_count;
        idx <= 5'h00;
      end else if (seq == fpm_pkg::seq_write) begin
        idx <= idx + 5'h01; // R1
      end
      if (seq == fpm_pkg::seq_write && last_byte) begin
        timer <= fpm_pkg::PROG_CYCLES - 10'h001;
      end else if (seq == fpm_pkg::seq_erase) begin
        timer <= fpm_pkg::ERASE_CYCLES - 10'h001;
      end else if (!timer_done) begin
        timer <= timer - 10'h001;
      end
    end
  end

  // Flash macro drive and status
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_write <= 1'b0;
      mem_erase <= 1'b0;
      mem_area <= fpm_pkg::AREA_PROGRAM;
      mem_addr <= 13'h0000;
      mem_wdata <= 8'h00;
      op_busy <= 1'b0;
      op_done <= 1'b0;
      op_refused <= 1'b0;
    end else begin
      // Unused latches raise no write strobe, so their cells stay untouched
      mem_write <= seq == fpm_pkg::seq_write && latch_used[idx]; // R1
      mem_erase <= seq == fpm_pkg::seq_erase; // R2
      mem_area <= cur_area;
      mem_addr <= {cur_row[12:5], idx}; // R2
      mem_wdata <= latch[idx];
      op_busy <= next_seq != fpm_pkg::seq_idle;
      op_done <= op_finish;
      op_refused <= op_reject; // R6
    end
  end
endmodule

// ===== include/fpm_pkg.sv
// Constants and types shared by the flash program-mode controller.
// Assumes a 250 MHz core clock and a link clock made by the tool.
// Notes on behaviour
// R1: Byte or up to 32-byte parallel programming
// R2: Erase touches only the addressed row
// R3: Sector 0 size set by option byte
// R4: Socket mode: all areas writable and erasable
// R5: In-circuit mode: all areas writable, board mounted
// R6: Self-programming: sector 0 and option row locked
// R7: Tool preloads self-programming driver into sector 0
// R8: Entry pattern on link pins during reset
// R9: In-circuit entry fetches system memory vector
// R10: Enter, download driver bytes, then execute
// R11: Tool cable uses four to six signals
// R12: Link bytes come on data pin, link clock
// R13: External clock pin accepted for programming
// R14: Software writes key 56h then AEh first
// R15: Any reset returns clock pin to pulled-up input
// R16: In-circuit mode held until next reset
package fpm_pkg;
  localparam int ADDR_W = 13;
  localparam int LATCH_DEPTH = 32;
  localparam int LATCH_AW = 5;
  localparam int COUNT_W = 6;
  localparam logic [COUNT_W-1:0] MAX_BURST = 6'h20;
  localparam logic [7:0] KEY_FIRST = 8'h56;
  localparam logic [7:0] KEY_SECOND = 8'hAE;
  // Entry pattern shifted in MSB first while reset is held low
  localparam logic [7:0] ENTRY_PATTERN = 8'hB9;
  localparam logic [15:0] USER_RESET_VECTOR = 16'hFFFE;
  localparam logic [15:0] SYSTEM_RESET_VECTOR = 16'hEFFE;
  // Sector 0 top address per option byte setting
  localparam logic [ADDR_W-1:0] SECTOR0_SIZE_0 = 13'h0200;
  localparam logic [ADDR_W-1:0] SECTOR0_SIZE_1 = 13'h0400;
  localparam logic [ADDR_W-1:0] SECTOR0_SIZE_2 = 13'h0800;
  localparam logic [ADDR_W-1:0] SECTOR0_SIZE_3 = 13'h1000;
  localparam logic [1:0] AREA_PROGRAM = 2'h0;
  localparam logic [1:0] AREA_OPTION = 2'h1;
  localparam logic [1:0] AREA_EEPROM = 2'h2;
  localparam logic [1:0] PMODE_SELF = 2'h0;
  localparam logic [1:0] PMODE_SOCKET = 2'h1;
  localparam logic [1:0] PMODE_INCIRCUIT = 2'h2;
  localparam logic [1:0] STEP_OFF = 2'h0;
  localparam logic [1:0] STEP_ENTER = 2'h1;
  localparam logic [1:0] STEP_DOWNLOAD = 2'h2;
  localparam logic [1:0] STEP_EXECUTE = 2'h3;
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int PROG_TIME_NS = 1000;
  localparam int ERASE_TIME_NS = 2000;
  localparam int TIMER_W = 10;
  localparam logic [TIMER_W-1:0] PROG_CYCLES =
    TIMER_W'((PROG_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] ERASE_CYCLES =
    TIMER_W'((ERASE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  typedef enum logic [1:0] {seq_idle, seq_write, seq_erase, seq_wait} fpm_seq_t;
  typedef enum logic [1:0] {key_locked, key_half, key_open} fpm_key_t;
endpackage

// ===== design/fpm_link_rx.sv
// Link-clock side of the in-circuit link: entry pattern and byte receiver.
// Runs on the tool's link clock, which may stop between frames.
`timescale 1ns/1ps
module fpm_link_rx (
  // Link clock and reset
  input wire logic link_clock,
  input wire logic rst,
  // Pins
  input wire logic data_pin_in,
  input wire logic reset_pin_n_in,
  // Crossing outputs
  output logic entry_toggle,
  output logic byte_toggle,
  output logic [7:0] byte_hold
);
  logic rpin_s1;
  logic rpin_s2;
  logic rpin_s3;
  logic held_low;
  logic entered;
  logic [7:0] shift;
  logic [2:0] bit_count;
  wire [7:0] next_shift = {shift[6:0], data_pin_in};
  wire pattern_hit = held_low && !entered && (next_shift == fpm_pkg::ENTRY_PATTERN);
  wire byte_end = !held_low && entered && (bit_count == 3'h7);

  always_ff @(posedge link_clock or posedge rst) begin
    if (rst) begin
      rpin_s1 <= 1'b1;
      rpin_s2 <= 1'b1;
      rpin_s3 <= 1'b1;
      held_low <= 1'b0;
    end else begin
      rpin_s1 <= reset_pin_n_in;
      rpin_s2 <= rpin_s1;
      rpin_s3 <= rpin_s2;
      if (rpin_s2 == rpin_s3) begin
        held_low <= !rpin_s3;
      end
    end
  end

  always_ff @(posedge link_clock or posedge rst) begin
    if (rst) begin
      shift <= 8'h00;
      bit_count <= 3'h0;
      entered <= 1'b0;
      entry_toggle <= 1'b0;
      byte_toggle <= 1'b0;
      byte_hold <= 8'h00;
    end else begin
      shift <= next_shift; // R12
      if (pattern_hit) begin
        entered <= 1'b1; // R8
        entry_toggle <= !entry_toggle;
      end
      // Byte framing restarts whenever reset is held
      bit_count <= held_low ? 3'h0 : bit_count + 3'h1;
      if (byte_end) begin
        byte_hold <= next_shift; // R12
        byte_toggle <= !byte_toggle;
      end
    end
  end
endmodule

// ===== test/fpm_ctrl_properties.sv
// Port checker for the flash program-mode controller.
// Assumes binding onto fpm_flash_ctrl; all checks on the core clock.
`timescale 1ns/1ps
module fpm_ctrl_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Requests
  input wire logic op_start,
  input wire logic op_erase,
  input wire logic [5:0] op_count,
  input wire logic [1:0] option_sector0_size,
  // Status
  input wire logic op_busy,
  input wire logic op_done,
  input wire logic op_refused,
  input wire logic [1:0] program_mode,
  input wire logic [1:0] incircuit_step,
  input wire logic [15:0] boot_vector,
  input wire logic core_hold,
  input wire logic rx_valid,
  // Pins
  input wire logic incircuit_link_clock_pin_oe,
  input wire logic incircuit_link_clock_pin_pullup,
  input wire logic incircuit_link_data_pin_oe,
  // Flash macro
  input wire logic mem_write,
  input wire logic mem_erase,
  input wire logic [1:0] mem_area,
  input wire logic [12:0] mem_addr
);
  wire logic [12:0] sec_top = option_sector0_size[1] ?
    (option_sector0_size[0] ? fpm_pkg::SECTOR0_SIZE_3 : fpm_pkg::SECTOR0_SIZE_2) :
    (option_sector0_size[0] ? fpm_pkg::SECTOR0_SIZE_1 : fpm_pkg::SECTOR0_SIZE_0);
  wire logic self_mode = program_mode == fpm_pkg::PMODE_SELF;
  wire logic take = op_start && !op_busy && !core_hold;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_count_limit: assert property (take && !op_erase && (op_count == 6'h00 ||
    op_count > fpm_pkg::MAX_BURST) |-> ##1 op_refused) else $error("bad count accepted");
  a_write_in_op: assert property (mem_write |-> op_busy)
    else $error("write outside an operation");
  a_done_pulse: assert property (op_done |=> !op_done && !op_busy)
    else $error("done not a single pulse");
  a_erase_pulse: assert property (mem_erase |-> op_busy ##1 !mem_erase)
    else $error("erase strobe too long");
  a_self_lock: assert property (mem_write && self_mode |-> mem_area == fpm_pkg::AREA_EEPROM ||
    (mem_area == fpm_pkg::AREA_PROGRAM && mem_addr >= sec_top)) else $error("locked area written");
  a_refused_pulse: assert property (op_refused |-> !op_busy ##1 !op_refused)
    else $error("refusal not a single pulse");
  a_step_gate: assert property (take && program_mode == fpm_pkg::PMODE_INCIRCUIT &&
    incircuit_step != fpm_pkg::STEP_EXECUTE |-> ##1 op_refused) else $error("op before execute");
  a_boot_system: assert property (incircuit_step != fpm_pkg::STEP_OFF |->
    boot_vector == fpm_pkg::SYSTEM_RESET_VECTOR) else $error("wrong boot vector");
  a_mode_sticky: assert property (program_mode == fpm_pkg::PMODE_INCIRCUIT && !core_hold |=>
    program_mode == fpm_pkg::PMODE_INCIRCUIT) else $error("link mode left");
  a_hold_pin_input: assert property (core_hold |-> incircuit_link_clock_pin_pullup &&
    !incircuit_link_clock_pin_oe) else $error("clock pin driven in reset");
  a_data_receive_only: assert property (!incircuit_link_data_pin_oe)
    else $error("data pin driven");

  c_done: cover property (op_done);
  c_refused: cover property (op_refused);
  c_rx: cover property (rx_valid);
  c_execute: cover property (incircuit_step == fpm_pkg::STEP_EXECUTE);
endmodule

bind fpm_flash_ctrl fpm_ctrl_properties u_fpm_ctrl_properties (.*);

// ===== test/fpm_tool_model.sv
// Behavioural programming tool at the far end of the cable.
// Assumes the bench merges its lines with the device's pin drivers.
`timescale 1ns/1ps
module fpm_tool_model (
  // Cable lines besides ground
  output logic link_clock,
  output logic data,
  output logic reset_pin_n,
  output logic clock_supply
);
  initial begin
    link_clock = 1'b1;
    data = 1'b1;
    reset_pin_n = 1'b1;
    clock_supply = 1'b0;
  end

  // Clock idles high between frames; data flips after a frame so a stale bit never helps
  task automatic shift(input logic [15:0] v, input int n);
    #1.3;
    for (int i = n - 1; i >= 0; i--) begin
      link_clock = 1'b0;
      data = v[i];
      #24;
      link_clock = 1'b1;
      #24;
    end
    data = ~data;
  endtask

  // Leading zeros cover the link-side reset synchroniser
  task automatic enter_incircuit();
    reset_pin_n = 1'b0;
    #100;
    shift({8'h00, fpm_pkg::ENTRY_PATTERN}, 16);
    reset_pin_n = 1'b1;
    shift(16'hFFFF, 4);
  endtask

  task automatic send_byte(input logic [7:0] b);
    shift({8'h00, b}, 8);
  endtask

  task automatic set_reset(input logic v);
    reset_pin_n = v;
  endtask

  task automatic supply(input logic v);
    clock_supply = v;
  endtask
endmodule

// ===== test/test_flash_program_mode_control.sv
// Self-checking bench for the flash program-mode controller.
// Assumes the tool model drives the cable; core signals change on falling edges.
`timescale 1ns/1ps
module test_flash_program_mode_control;
  logic clock, rst, socket_strap_in, external_clock_present_in, app_clock_pin_drive;
  logic app_clock_pin_value, key_write, latch_write, op_start, op_erase, driver_start;
  logic [1:0] option_sector0_size, op_area, program_mode, incircuit_step, mem_area, wa_area;
  logic [7:0] key_data, latch_data, rx_byte, mem_wdata, wd, rx_last, rx_prev;
  logic [4:0] latch_index;
  logic [12:0] op_row_addr, mem_addr, wa, ea;
  logic [5:0] op_count;
  logic [15:0] boot_vector;
  logic clk_out, clk_oe, clk_pu, dat_out, dat_oe, op_busy, op_done, op_refused, core_hold;
  logic use_external_clock, rx_valid, mem_write, mem_erase;
  logic tool_clk, tool_dat, tool_rst_n, link_pin, data_pin;
  int miscompares, cmp_count, cycles, wr_cnt, er_cnt, done_cnt, ref_cnt, rx_cnt;

  assign link_pin = clk_oe ? clk_out : tool_clk;
  assign data_pin = dat_oe ? dat_out : tool_dat;

  fpm_tool_model u_fpm_tool_model (.link_clock(tool_clk), .data(tool_dat),
    .reset_pin_n(tool_rst_n), .clock_supply(external_clock_present_in));

  fpm_flash_ctrl u_fpm_flash_ctrl (.*, .reset_pin_n_in(tool_rst_n),
    .incircuit_link_clock_pin(link_pin), .incircuit_link_data_pin_in(data_pin),
    .incircuit_link_clock_pin_out(clk_out), .incircuit_link_clock_pin_oe(clk_oe),
    .incircuit_link_clock_pin_pullup(clk_pu), .incircuit_link_data_pin_out(dat_out),
    .incircuit_link_data_pin_oe(dat_oe));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    if (mem_write) begin
      wr_cnt++;
      wa = mem_addr;
      wd = mem_wdata;
      wa_area = mem_area;
    end
    if (mem_erase) begin
      er_cnt++;
      ea = mem_addr;
    end
    if (op_done) done_cnt++;
    if (op_refused) ref_cnt++;
    if (rx_valid) begin
      rx_cnt++;
      rx_prev = rx_last;
      rx_last = rx_byte;
    end
  end

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard far above the longest run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end

  function automatic bit bad(input bit c);
    cmp_count++;
    return !c;
  endfunction

  task automatic fail(input string msg);
    miscompares++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wait_ready();
    for (int t = 0; t < 100 && core_hold !== 1'b0; t++) idle(1);
  endtask

  task automatic pulse_key(input logic [7:0] k);
    @(negedge clock);
    key_write = 1'b1;
    key_data = k;
    @(negedge clock);
    key_write = 1'b0;
  endtask

  task automatic fill(input logic [4:0] i, input logic [7:0] d);
    @(negedge clock);
    latch_write = 1'b1;
    latch_index = i;
    latch_data = d;
    @(negedge clock);
    latch_write = 1'b0;
  endtask

  // Unlocks, starts one operation and waits for done or refusal
  task automatic run_op(input logic e, input logic [1:0] a, input logic [12:0] r,
                        input logic [5:0] n, input bit ok);
    int d0 = done_cnt;
    int r0 = ref_cnt;
    pulse_key(fpm_pkg::KEY_FIRST);
    pulse_key(fpm_pkg::KEY_SECOND);
    @(negedge clock);
    op_start = 1'b1;
    op_erase = e;
    op_area = a;
    op_row_addr = r;
    op_count = n;
    @(negedge clock);
    op_start = 1'b0;
    for (int t = 0; t < 700 && done_cnt == d0 && ref_cnt == r0; t++) idle(1);
    if (bad(ok ? done_cnt == d0 + 1 : ref_cnt == r0 + 1)) fail("op outcome");
  endtask

  task automatic t_reset_pin();
    if (bad(clk_pu === 1'b1 && clk_oe === 1'b0)) fail("pin not input");
    if (bad(dat_oe === 1'b0 && dat_out === 1'b0)) fail("data pin");
    if (bad(boot_vector === fpm_pkg::USER_RESET_VECTOR)) fail("user vector");
    app_clock_pin_drive = 1'b1;
    app_clock_pin_value = 1'b0;
    idle(5);
    if (bad(clk_oe === 1'b1 && clk_out === 1'b0)) fail("app drive");
    u_fpm_tool_model.set_reset(1'b0);
    idle(10);
    if (bad(clk_oe === 1'b0 && clk_pu === 1'b1 && core_hold === 1'b1)) fail("pin reset");
    app_clock_pin_drive = 1'b0;
    u_fpm_tool_model.set_reset(1'b1);
    wait_ready();
  endtask

  task automatic t_self();
    int w0;
    int e0;
    for (int i = 0; i < 32; i++) fill(5'(i), 8'(i));
    w0 = wr_cnt;
    run_op(1'b0, fpm_pkg::AREA_PROGRAM, 13'h1FE0, fpm_pkg::MAX_BURST, 1);
    if (bad(wr_cnt == w0 + 32 && wa === 13'h1FFF && wd === 8'h1F)) fail("burst");
    run_op(1'b0, fpm_pkg::AREA_PROGRAM, 13'h1FE0, 6'h21, 0);
    run_op(1'b0, fpm_pkg::AREA_PROGRAM, 13'h0100, 6'h01, 0);
    run_op(1'b0, fpm_pkg::AREA_OPTION, 13'h0000, 6'h01, 0);
    option_sector0_size = 2'h3;
    run_op(1'b0, fpm_pkg::AREA_PROGRAM, 13'h0800, 6'h01, 0);
    option_sector0_size = 2'h0;
    fill(5'h00, 8'hC3);
    run_op(1'b0, fpm_pkg::AREA_PROGRAM, 13'h0800, 6'h01, 1);
    if (bad(wa === 13'h0800 && wd === 8'hC3)) fail("row write");
    e0 = er_cnt;
    w0 = wr_cnt;
    run_op(1'b1, fpm_pkg::AREA_PROGRAM, 13'h1FE0, 6'h01, 1);
    if (bad(er_cnt == e0 + 1 && ea === 13'h1FE0 && wr_cnt == w0)) fail("erase");
  endtask

  task automatic t_incircuit();
    int r0;
    u_fpm_tool_model.enter_incircuit();
    idle(40);
    if (bad(boot_vector === fpm_pkg::SYSTEM_RESET_VECTOR)) fail("system vector");
    if (bad(program_mode === fpm_pkg::PMODE_INCIRCUIT)) fail("link mode");
    if (bad(incircuit_step === fpm_pkg::STEP_DOWNLOAD)) fail("download step");
    r0 = rx_cnt;
    u_fpm_tool_model.send_byte(8'hA5);
    u_fpm_tool_model.send_byte(8'h3C);
    idle(20);
    if (bad(rx_cnt == r0 + 2 && rx_prev === 8'hA5 && rx_last === 8'h3C)) fail("bytes");
    fill(5'h00, 8'h5A);
    run_op(1'b0, fpm_pkg::AREA_PROGRAM, 13'h0000, 6'h01, 0);
    driver_start = 1'b1;
    idle(1);
    driver_start = 1'b0;
    idle(3);
    if (bad(incircuit_step === fpm_pkg::STEP_EXECUTE)) fail("execute step");
    fill(5'h00, 8'h5A);
    run_op(1'b0, fpm_pkg::AREA_PROGRAM, 13'h0000, 6'h01, 1);
    if (bad(wa === 13'h0000 && wd === 8'h5A)) fail("sector 0 write");
    u_fpm_tool_model.supply(1'b1);
    idle(10);
    if (bad(use_external_clock === 1'b1)) fail("external clock");
    u_fpm_tool_model.supply(1'b0);
    if (bad(program_mode === fpm_pkg::PMODE_INCIRCUIT)) fail("mode kept");
  endtask

  task automatic t_socket();
    rst = 1'b1;
    socket_strap_in = 1'b1;
    idle(3);
    rst = 1'b0;
    wait_ready();
    if (bad(program_mode === fpm_pkg::PMODE_SOCKET)) fail("socket mode");
    fill(5'h00, 8'h77);
    run_op(1'b0, fpm_pkg::AREA_OPTION, 13'h0000, 6'h01, 1);
    if (bad(wa_area === fpm_pkg::AREA_OPTION && wd === 8'h77)) fail("option write");
    run_op(1'b1, fpm_pkg::AREA_PROGRAM, 13'h0000, 6'h01, 1);
  endtask

  initial begin
    rst = 1'b1;
    {socket_strap_in, app_clock_pin_drive, app_clock_pin_value} = 3'h1;
    {key_write, latch_write, op_start, op_erase, driver_start} = 5'h00;
    {option_sector0_size, op_area, key_data, latch_data, latch_index} = 25'h0000000;
    {op_row_addr, op_count} = 19'h00000;
    repeat (12) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    wait_ready();
    t_reset_pin();
    t_self();
    t_incircuit();
    t_socket();
    end_sim();
  end
endmodule
